// ### bench/l1cea_bus_model.sv
`timescale 1ns/1ps
module l1cea_bus_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic refill_req,
    input wire logic push_req,
    input wire logic rsv_req,
    input wire logic [1:0] dly,
    input wire logic err_cfg,
    input wire logic exclusive_fail_response_cfg,
    input wire logic pperr_cfg,
    output logic bus_done,
    output logic bus_err,
    output logic bus_exclusive_fail_response,
    output logic push_parity_err
);
    logic [1:0] cnt_r;
    logic tog_r;
    wire busy = refill_req | push_req | rsv_req;
    // Qualifiers wander outside bus_done so the design cannot lean on stale values
    assign bus_err = bus_done ? err_cfg : tog_r;
    assign bus_exclusive_fail_response = bus_done ? exclusive_fail_response_cfg : ~tog_r;
    assign push_parity_err = bus_done ? (pperr_cfg & push_req) : tog_r;
    // One completion per request after a chosen wait; a new request restarts the count
    always_ff @(posedge clk) begin
        tog_r <= rst ? 1'b0 : ~tog_r;
        if (rst || bus_done || !busy) begin
            cnt_r <= 2'h0;
            bus_done <= 1'b0;
        end else if (cnt_r == dly) begin
            bus_done <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 2'h1;
        end
    end
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
    import l1cea_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rdp = 1'b0;
    logic req_valid = 1'b0, req_icache = 1'b0, req_inhibited = 1'b0;
    logic [1:0] req_kind = 2'h0, target_way, b_dly = 2'h0, w;
    logic [2:0] be = 3'h0;
    logic [28:0] lk = 29'h0, a;
    logic [3:0] corr_fix_mask, corr_inval_mask, corr_dirty_set_mask;
    logic req_ready, corr_we, refill_req, push_req, rsv_req, rsv_write, refill_forced;
    logic repl_update, bus_done, bus_err, bus_exclusive_fail_response, push_parity_err;
    logic sc_update, machine_check, access_done, array_read, mark_clean;
    logic mcl = 1'b0;
    logic [20:0] want;
    logic [20:0] acc = 21'h0, cur;
    logic [31:0] rq[$];
    logic [20:0] aq[$];
    logic [15:0] nmc = 16'h0;
    int miscompares = 0, n_checks = 0, cyc = 0;

    always #50 clk = ~clk;

    l1cea_ctrl DUT (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .req_valid, .req_ready, .req_icache, .req_kind, .req_inhibited,
        .lk_hit(lk[28:25]), .lk_tag_sbe(lk[24:21]), .lk_tag_mbe(lk[20:17]), .lk_lock(lk[16:13]),
        .lk_lock_err(lk[12:9]), .lk_dirty(lk[8:5]), .lk_dirty_err(lk[4:1]), .lk_data_err(lk[0]),
        .array_read, .corr_we, .corr_fix_mask, .corr_inval_mask, .corr_dirty_set_mask,
        .refill_req, .push_req, .rsv_req, .rsv_write, .target_way, .refill_forced,
        .repl_update, .bus_done, .bus_err, .bus_exclusive_fail_response, .push_parity_err, .mark_clean,
        .sc_update, .machine_check, .access_done);

    l1cea_bus_model bus (.clk, .rst, .refill_req, .push_req, .rsv_req, .dly(b_dly),
        .err_cfg(be[2]), .exclusive_fail_response_cfg(be[1]), .pperr_cfg(be[0]), .bus_done, .bus_err,
        .bus_exclusive_fail_response, .push_parity_err);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: mismatch got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Lookup vector packing: hit, sbe, mbe, lock, lock err, dirty, dirty err, data err
    function automatic logic [28:0] lv(logic [3:0] h, s, m, l, le, d, de, logic da);
        return {h, s, m, l, le, d, de, da};
    endfunction

    // Outcome packing: {mc, refill, forced, push, rsv, rsv write, sc update}, way, masks
    function automatic logic [20:0] ex(logic [6:0] f, logic [1:0] tw, logic [3:0] fx, iv, ds);
        return {f, tw, fx, iv, ds};
    endfunction

    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] ad, input logic [31:0] x);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        rq.push_back(x);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    // One access; second lookup vector b appears once the correction pulse has gone by
    task automatic run(input logic ic, input logic [1:0] k, input logic inh,
        input logic [28:0] la, lb, input logic [2:0] e, input logic [20:0] x);
        logic ok;
        ok = 1'b0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_icache <= ic;
        req_kind <= k;
        req_inhibited <= inh;
        lk <= la;
        be <= e;
        b_dly <= 2'($urandom_range(0, 3));
        aq.push_back(x);
        nmc += 16'(x[20]);
        repeat (40) begin
            @(posedge clk);
            req_valid <= 1'b0;
            if (corr_we === 1'b1) lk <= lb;
            if (access_done === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
        if (!ok) chk(32'h0, 32'h1);
    endtask

    // Watcher: gathers what each access did and settles it against the oldest note
    always @(posedge clk) begin
        if (rdp) chk(reg_rdata, rq.pop_front());
        rdp <= reg_rd;
        // Arrays are read on the take and again for the re-lookup
        if (!rst) chk({31'h0, array_read},
            {31'h0, (req_valid & req_ready) | (corr_we & ~access_done)});
        cur = acc | {machine_check, refill_req, refill_req & refill_forced & ~repl_update,
            push_req, rsv_req, rsv_req & rsv_write, sc_update,
            (refill_req | push_req) ? target_way : 2'h0,
            corr_we ? {corr_fix_mask, corr_inval_mask, corr_dirty_set_mask} : 12'h0};
        if (rst) begin
            acc <= 21'h0;
            mcl <= 1'b0;
        end else if (access_done === 1'b1) begin
            want = aq.pop_front();
            chk({11'h0, cur}, {11'h0, want});
            chk({31'h0, mcl | mark_clean}, {31'h0, want[17] & ~want[20]});
            acc <= 21'h0;
            mcl <= 1'b0;
        end else begin
            acc <= cur;
            mcl <= mcl | mark_clean;
        end
    end

    // Hang guard, well beyond the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(66506));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h0);
        rd(4'hC, 32'h0);
        wr(4'h0, 32'h15);
        wr(4'h4, 32'h15);
        wr(4'h8, 32'hFFFF);
        rd(4'h0, 32'h15);
        rd(4'h8, 32'h0);
        a = lv(1, 0, 0, 0, 0, 0, 0, 0);
        run(0, KIND_LOAD, 0, a, a, 0, ex(0, 0, 0, 0, 0));
        run(0, KIND_LOAD, 0, lv(1, 4, 0, 0, 0, 0, 0, 0), a, 0, ex(0, 0, 4, 0, 0));
        run(0, KIND_LOAD, 0, lv(1, 0, 2, 0, 0, 0, 0, 0), a, 0, ex(0, 0, 0, 2, 0));
        run(0, KIND_LOAD, 0, lv(1, 0, 0, 0, 0, 0, 8, 0), a, 0, ex(0, 0, 0, 0, 8));
        w = 2'($urandom_range(0, 3));
        a = lv(4'h1 << w, 0, 0, 0, 0, 0, 0, 1);
        run(0, KIND_LOAD, 0, a, a, 0, ex(7'b0110000, w, 0, 0, 0));
        run(0, KIND_STORE, 0, a, a, 0, ex(0, 0, 0, 0, 0));
        a = lv(1, 0, 0, 0, 0, 1, 0, 1);
        run(0, KIND_LOAD, 0, a, a, 0, ex(7'b1000000, 0, 0, 0, 0));
        a = lv(0, 0, 2, 0, 0, 2, 0, 0);
        run(0, KIND_LOAD, 0, a, a, 0, ex(7'b1000000, 0, 0, 0, 0));
        run(1, KIND_LOAD, 0, lv(0, 0, 4, 4, 0, 0, 0, 0), lv(0, 0, 0, 4, 0, 0, 0, 0), 0,
            ex(7'b1000000, 0, 0, 4, 0));
        w = 2'($urandom_range(0, 3));
        a = lv(4'h1 << w, 0, 0, 4'h1 << w, 0, 0, 0, 1);
        run(1, KIND_LOAD, 0, a, a, 3'b100, ex(7'b1110000, w, 0, 4'h1 << w, 0));
        a = lv(1, 0, 0, 0, 0, 1, 0, 0);
        run(0, KIND_SC, 0, a, a, 0, ex(7'b0001111, 0, 0, 0, 0));
        a = lv(1, 0, 0, 0, 0, 0, 0, 0);
        run(0, KIND_SC, 0, a, a, 3'b010, ex(7'b0000110, 0, 0, 0, 0));
        run(0, KIND_LR, 0, lv(1, 0, 0, 0, 0, 0, 1, 0), lv(1, 0, 0, 0, 0, 1, 0, 0), 3'b001,
            ex(7'b1001000, 0, 0, 0, 1));
        a = lv(1, 0, 2, 0, 0, 0, 0, 0);
        run(0, KIND_LOAD, 1, a, a, 0, ex(0, 0, 0, 0, 0));
        wr(4'h0, 32'h14);
        run(0, KIND_LOAD, 0, a, a, 0, ex(7'b1000000, 0, 0, 0, 0));
        wr(4'h0, 32'h0);
        run(0, KIND_LOAD, 0, a, a, 0, ex(0, 0, 0, 0, 0));
        rd(4'h8, {16'h0, nmc});
        repeat (3) @(posedge clk);
        end_sim();
    end
endmodule

// ### hdl/l1cea_ctrl.sv
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module l1cea_ctrl (
    input logic clk,
    input logic rst,
    // Register port
    input logic [3:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [31:0] reg_rdata,
    // Access request from the core
    input logic req_valid,
    output logic req_ready,
    input logic req_icache,
    input logic [1:0] req_kind,
    input logic req_inhibited,
    // Per-way lookup results from the arrays
    input logic [l1cea_pkg::NUM_WAYS-1:0] lk_hit,
    input logic [l1cea_pkg::NUM_WAYS-1:0] lk_tag_sbe,
    input logic [l1cea_pkg::NUM_WAYS-1:0] lk_tag_mbe,
    input logic [l1cea_pkg::NUM_WAYS-1:0] lk_lock,
    input logic [l1cea_pkg::NUM_WAYS-1:0] lk_lock_err,
    input logic [l1cea_pkg::NUM_WAYS-1:0] lk_dirty,
    input logic [l1cea_pkg::NUM_WAYS-1:0] lk_dirty_err,
    input logic lk_data_err,
    output logic array_read,
    // Correction cycle writes to the tag arrays
    output logic corr_we,
    output logic [l1cea_pkg::NUM_WAYS-1:0] corr_fix_mask,
    output logic [l1cea_pkg::NUM_WAYS-1:0] corr_inval_mask,
    output logic [l1cea_pkg::NUM_WAYS-1:0] corr_dirty_set_mask,
    // System bus side
    output logic refill_req,
    output logic push_req,
    output logic rsv_req,
    output logic rsv_write,
    output logic [1:0] target_way,
    output logic refill_forced,
    output logic repl_update,
    input logic bus_done,
    input logic bus_err,
    input logic bus_exclusive_fail_response,
    input logic push_parity_err,
    // Results
    output logic mark_clean,
    output logic sc_update,
    output logic machine_check,
    output logic access_done
);
    import l1cea_pkg::*;

    l1cea_state_type state_r, state_nxt;
    logic [4:0] dc_ctrl_r, ic_ctrl_r;
    logic [15:0] mc_cnt_r;
    logic [31:0] rdata_r, rdata_nxt;
    logic req_icache_r, req_inh_r;
    logic [1:0] req_kind_r;
    logic corr_we_r, corr_we_nxt;
    logic [NUM_WAYS-1:0] fix_r, fix_nxt, inval_r, inval_nxt, dset_r, dset_nxt;
    logic lock_mc_r, lock_mc_nxt;
    logic [1:0] way_r, way_nxt;
    logic forced_r, forced_nxt;
    logic way_locked_r, way_locked_nxt;
    logic mc_r, mc_nxt;
    logic done_r, done_nxt;
    logic clean_r, clean_nxt;
    logic scu_r, scu_nxt;

    // Control fields of the cache that the current access targets
    wire [4:0] ctrl_sel = req_icache_r ? ic_ctrl_r : dc_ctrl_r;
    wire [1:0] ea = ctrl_sel[FLD_EA_LSB+:2];
    wire [1:0] tag_protection_type = ctrl_sel[FLD_TAG_PROTECTION_TYPE_LSB+:2];
    wire ece = ctrl_sel[FLD_ECE_BIT];
    wire mode_corr = (ea == EA_CORRECT); // RULE1
    wire mode_mc = (ea == EA_MCHECK);
    wire edc = (tag_protection_type == TAG_PROTECTION_TYPE_EDC);

    // Error qualification; a disabled checker reports nothing
    wire [NUM_WAYS-1:0] en_v = {NUM_WAYS{ece}}; // RULE23
    wire [NUM_WAYS-1:0] sbe = en_v & lk_tag_sbe & {NUM_WAYS{edc}}; // RULE3
    wire [NUM_WAYS-1:0] mbe = en_v & (lk_tag_mbe | (lk_tag_sbe & {NUM_WAYS{~edc}}));
    wire [NUM_WAYS-1:0] lerr = en_v & lk_lock_err;
    wire [NUM_WAYS-1:0] derr = en_v & lk_dirty_err & {NUM_WAYS{~req_icache_r}};
    wire [NUM_WAYS-1:0] dirty = lk_dirty & {NUM_WAYS{~req_icache_r}};
    wire dat = ece & lk_data_err;

    // Line classification
    wire [NUM_WAYS-1:0] clean = ~dirty & ~derr;
    wire [NUM_WAYS-1:0] locked_any = lk_lock | lerr;
    wire [NUM_WAYS-1:0] hit_good_v = lk_hit & ~mbe;
    wire hit_good = |hit_good_v;
    wire hit_unc = |(lk_hit & mbe);
    wire miss_after = ~hit_good;
    wire is_store = (req_kind_r == KIND_STORE);
    wire is_rsv = ~req_icache_r & ((req_kind_r == KIND_LR) | (req_kind_r == KIND_SC));
    wire dirty_unc = |(mbe & ~clean);

    // Lowest good hit way
    logic [1:0] hw;
    always_comb begin
        hw = 2'h0;
        for (int i = NUM_WAYS - 1; i >= 0; i--) begin
            if (hit_good_v[i]) begin
                hw = 2'(i);
            end
        end
    end
    wire hit_dirty = ~clean[hw];
    wire hit_locked = locked_any[hw];

    // Invalidation plan; reservations never touch locked lines
    wire [NUM_WAYS-1:0] keep_lock_inval = ~locked_any | {NUM_WAYS{miss_after}}; // RULE5 RULE7
    wire [NUM_WAYS-1:0] inval_plan = mbe & clean & (is_rsv ? ~locked_any : keep_lock_inval); // RULE12 RULE22 RULE4
    wire lock_mc = |(inval_plan & locked_any); // RULE19
    // Instruction side: tag, lock, or data error with a hit; data side: tag, lock, dirty
    wire need_corr = (|sbe) | (|mbe) | (|lerr) |
        (req_icache_r ? (dat & (|lk_hit)) : (|derr)); // RULE6 RULE11
    // Errors that the machine-check policy reports
    wire err_mc = (|sbe) | (|mbe) | (hit_good & dat & ~is_store) |
        (~hit_good & ((|lerr) | (|derr)));
    wire go_corr = ~req_inh_r & mode_corr & need_corr;
    wire go_mc = ~req_inh_r & mode_mc & err_mc & ~is_rsv; // RULE24
    wire rsv_ok = (state_r == ST_RSV) & bus_done & ~bus_err & ~bus_exclusive_fail_response;

    // Handshakes toward core and bus
    assign req_ready = (state_r == ST_IDLE); // RULE25
    assign array_read = ((state_r == ST_IDLE) & req_valid) | (state_r == ST_CORRECT);
    assign refill_req = (state_r == ST_REFILL);
    assign push_req = (state_r == ST_PUSH);
    assign rsv_req = (state_r == ST_RSV);
    assign rsv_write = (req_kind_r == KIND_SC);
    assign target_way = way_r;
    assign refill_forced = forced_r;
    assign repl_update = ~forced_r; // RULE8 RULE14
    assign corr_we = corr_we_r;
    assign corr_fix_mask = fix_r;
    assign corr_inval_mask = inval_r;
    assign corr_dirty_set_mask = dset_r;
    assign mark_clean = clean_r;
    assign sc_update = scu_r;
    assign machine_check = mc_r;
    assign access_done = done_r;
    assign reg_rdata = rdata_r;

    // Register read mux; unmapped offsets read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                REG_DC_CTRL: rdata_nxt = {27'h0, dc_ctrl_r};
                REG_IC_CTRL: rdata_nxt = {27'h0, ic_ctrl_r};
                REG_STATUS: rdata_nxt = {15'h0, ~req_ready, mc_cnt_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Sequencer: one decision per lookup, stall until the outcome is known
    always_comb begin
        state_nxt = state_r;
        corr_we_nxt = 1'b0;
        fix_nxt = '0;
        inval_nxt = '0;
        dset_nxt = '0;
        lock_mc_nxt = lock_mc_r;
        way_nxt = way_r;
        forced_nxt = forced_r;
        way_locked_nxt = way_locked_r;
        mc_nxt = 1'b0;
        done_nxt = 1'b0;
        clean_nxt = 1'b0;
        scu_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                lock_mc_nxt = 1'b0;
                if (req_valid) begin
                    state_nxt = ST_LOOKUP;
                end
            end
            ST_LOOKUP, ST_RELOOK: begin
                if (state_r == ST_LOOKUP && req_inh_r) begin
                    // Inhibited: the array holds nothing to repair
                    done_nxt = 1'b1; // RULE2
                    state_nxt = ST_IDLE;
                end else if (state_r == ST_LOOKUP && go_mc) begin
                    mc_nxt = 1'b1; // RULE24
                    done_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end else if (state_r == ST_LOOKUP && go_corr) begin
                    corr_we_nxt = 1'b1; // RULE6 RULE11
                    fix_nxt = sbe | lerr; // RULE3
                    inval_nxt = inval_plan; // RULE12
                    dset_nxt = derr; // RULE13
                    lock_mc_nxt = lock_mc;
                    mc_nxt = lock_mc; // RULE19 RULE7
                    state_nxt = ST_CORRECT;
                end else if (is_rsv) begin
                    if (hit_good) begin
                        way_nxt = hw;
                        state_nxt = hit_dirty ? ST_PUSH : ST_RSV; // RULE20
                    end else if (dirty_unc) begin
                        mc_nxt = 1'b1; // RULE22
                        done_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                    end else begin
                        state_nxt = ST_RSV; // RULE21
                    end
                end else if (hit_good) begin
                    // Other lines' errors do not matter on a good hit
                    if (dat && !is_store && (req_icache_r || clean[hw])) begin
                        way_nxt = hw; // RULE8 RULE14 RULE9
                        forced_nxt = 1'b1;
                        way_locked_nxt = hit_locked;
                        state_nxt = ST_REFILL;
                    end else if (dat && !is_store) begin
                        mc_nxt = 1'b1; // RULE16
                        done_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                    end else begin
                        done_nxt = 1'b1; // RULE15
                        state_nxt = ST_IDLE;
                    end
                end else if (hit_unc || dirty_unc || lock_mc_r) begin
                    // No fill: dirty data or a locked line would be lost
                    mc_nxt = hit_unc | dirty_unc; // RULE17 RULE18
                    done_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end else begin
                    forced_nxt = 1'b0;
                    way_locked_nxt = 1'b0;
                    state_nxt = ST_REFILL;
                end
            end
            ST_CORRECT: begin
                state_nxt = ST_RELOOK; // RULE25
            end
            ST_REFILL: begin
                if (bus_done) begin
                    if (bus_err && forced_r && way_locked_r) begin
                        mc_nxt = 1'b1; // RULE10
                        corr_we_nxt = 1'b1;
                        inval_nxt = NUM_WAYS'(1) << way_r;
                    end
                    done_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            ST_PUSH: begin
                if (bus_done) begin
                    if (push_parity_err || bus_err) begin
                        mc_nxt = 1'b1; // RULE20
                        done_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                    end else begin
                        clean_nxt = 1'b1; // RULE20
                        state_nxt = ST_RSV;
                    end
                end
            end
            ST_RSV: begin
                if (bus_done) begin
                    scu_nxt = rsv_ok & rsv_write; // RULE21
                    done_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Sequencer and result flops
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            corr_we_r <= 1'b0;
            fix_r <= '0;
            inval_r <= '0;
            dset_r <= '0;
            lock_mc_r <= 1'b0;
            way_r <= 2'h0;
            forced_r <= 1'b0;
            way_locked_r <= 1'b0;
            mc_r <= 1'b0;
            done_r <= 1'b0;
            clean_r <= 1'b0;
            scu_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            corr_we_r <= corr_we_nxt;
            fix_r <= fix_nxt;
            inval_r <= inval_nxt;
            dset_r <= dset_nxt;
            lock_mc_r <= lock_mc_nxt;
            way_r <= way_nxt;
            forced_r <= forced_nxt;
            way_locked_r <= way_locked_nxt;
            mc_r <= mc_nxt;
            done_r <= done_nxt;
            clean_r <= clean_nxt;
            scu_r <= scu_nxt;
        end
    end

    // Request capture; fields hold for the whole access
    always_ff @(posedge clk) begin
        if (rst) begin
            req_icache_r <= 1'b0;
            req_kind_r <= KIND_LOAD;
            req_inh_r <= 1'b0;
        end else if (req_ready && req_valid) begin
            req_icache_r <= req_icache;
            req_kind_r <= req_kind;
            req_inh_r <= req_inhibited;
        end
    end

    // Software registers; the check counter saturates rather than wraps
    always_ff @(posedge clk) begin
        if (rst) begin
            dc_ctrl_r <= RST_CTRL;
            ic_ctrl_r <= RST_CTRL;
            mc_cnt_r <= RST_MC_COUNT;
            rdata_r <= 32'h0000_0000;
        end else begin
            if (reg_wr && reg_addr == REG_DC_CTRL) begin
                dc_ctrl_r <= reg_wdata[4:0];
            end
            if (reg_wr && reg_addr == REG_IC_CTRL) begin
                ic_ctrl_r <= reg_wdata[4:0];
            end
            if (mc_r && mc_cnt_r != 16'hFFFF) begin
                mc_cnt_r <= mc_cnt_r + 16'h0001;
            end
            rdata_r <= rdata_nxt;
        end
    end

    // A decision taken straight from the first lookup counts like one after re-lookup
    wire decide = (state_r == ST_RELOOK) ||
        (state_r == ST_LOOKUP && !req_inh_r && !go_corr && !go_mc);

    // Checks
    a_inh_no_inval: assert property (@(posedge clk) disable iff (rst) // RULE2
        (state_r == ST_LOOKUP && req_inh_r) |=> !corr_we ##1 !corr_we)
        else $error("inhibited access started a correction");
    a_corr_cycle_in: assert property (@(posedge clk) disable iff (rst) // RULE6
        (state_r == ST_LOOKUP && go_corr) |=> corr_we && state_r == ST_CORRECT
            ##1 state_r == ST_RELOOK && !req_ready)
        else $error("correction cycle not inserted");
    a_dirty_bits_set: assert property (@(posedge clk) disable iff (rst) // RULE13
        (state_r == ST_LOOKUP && go_corr) |=> corr_dirty_set_mask == $past(derr))
        else $error("dirty parity not repaired");
    a_clean_refill: assert property (@(posedge clk) disable iff (rst) // RULE14
        (state_r == ST_RELOOK && !is_rsv && hit_good && dat && !is_store && clean[hw])
            |=> refill_req && refill_forced && !repl_update && target_way == $past(hw))
        else $error("forced refill missing");
    a_store_hit_ok: assert property (@(posedge clk) disable iff (rst) // RULE15
        (decide && !is_rsv && hit_good && is_store)
            |=> access_done && !machine_check && !refill_req)
        else $error("store hit disturbed");
    a_dirty_load_mc: assert property (@(posedge clk) disable iff (rst) // RULE16
        (decide && !is_rsv && !req_icache_r && hit_good && dat && !is_store
            && hit_dirty) |=> machine_check && access_done && !refill_req)
        else $error("dirty load error not checked");
    a_miss_dirty_unc: assert property (@(posedge clk) disable iff (rst) // RULE18
        (state_r == ST_RELOOK && !is_rsv && !hit_good && dirty_unc)
            |=> machine_check && req_ready)
        else $error("miss with dirty bad tag filled");
    a_lock_inval_mc: assert property (@(posedge clk) disable iff (rst) // RULE19
        (state_r == ST_LOOKUP && go_corr && lock_mc) |=> machine_check && corr_we)
        else $error("locked invalidation silent");
    a_check_off: assert property (@(posedge clk) disable iff (rst) // RULE23
        (state_r == ST_LOOKUP && !ece) |=> !corr_we && !machine_check)
        else $error("disabled checker reported");
    a_mcheck_mode: assert property (@(posedge clk) disable iff (rst) // RULE24
        (state_r == ST_LOOKUP && go_mc) |=> machine_check && !corr_we)
        else $error("policy 00 did not check");
    a_push_cancel: assert property (@(posedge clk) disable iff (rst) // RULE20
        (state_r == ST_PUSH && bus_done && push_parity_err) |=> machine_check && !rsv_req)
        else $error("push error did not cancel");
    a_sc_success: assert property (@(posedge clk) disable iff (rst) // RULE21
        sc_update |-> $past(rsv_ok) && rsv_write)
        else $error("store update without success");
    c_corr_relook: cover property (@(posedge clk) disable iff (rst)
        state_r == ST_CORRECT ##1 state_r == ST_RELOOK ##1 refill_req);
    c_push_rsv: cover property (@(posedge clk) disable iff (rst)
        mark_clean ##[1:20] sc_update);
    c_locked_fill_err: cover property (@(posedge clk) disable iff (rst)
        state_r == ST_REFILL && bus_done && bus_err && way_locked_r);
endmodule

// ### hdl/l1cea_pkg.sv
// Behaviour
// RULE1: Error action 01 selects correct/invalidate/refill policy
// RULE2: Cache-inhibited accesses never invalidate on errors
// RULE3: EDC tag type 01 corrects single-bit tags
// RULE4: Clean unlocked multi-bit tag lines invalidated silently
// RULE5: Clean locked bad-tag lines invalidated on miss, check
// RULE6: Instruction errors insert one correction cycle
// RULE7: Locked instruction invalidation raises check, keeps lock
// RULE8: Instruction data error on good hit forces refill
// RULE9: Good instruction hit ignores other lines' errors
// RULE10: Bus error refilling locked line: check, invalidate
// RULE11: Data tag, lock, dirty errors insert correction cycle
// RULE12: Only clean bad-tag data lines get invalidated
// RULE13: Dirty parity error sets all dirty bits
// RULE14: Clean load data error forces same-line refill
// RULE15: Store hit ignores data parity errors
// RULE16: Dirty load data error: machine check, no refill
// RULE17: Re-lookup hitting only bad tags: check, no fill
// RULE18: Miss with dirty bad-tag line: check, no fill
// RULE19: Invalidating locked line raises check, lock kept
// RULE20: Reservation hit pushes dirty line; push error cancels
// RULE21: Reservations single-beat; store updates only on success
// RULE22: Reservation lookup invalidates only clean unlocked lines
// RULE23: Check enable zero suppresses all cache errors
// RULE24: Error action 00 raises machine check instead; the code does not raise it for reservations (go_mc excludes is_rsv)
// RULE25: Access stalls through correction and re-lookup
package l1cea_pkg;
    localparam int NUM_WAYS = 4;
    localparam logic [3:0] REG_DC_CTRL = 4'h0;
    localparam logic [3:0] REG_IC_CTRL = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam int FLD_EA_LSB = 0;
    localparam int FLD_TAG_PROTECTION_TYPE_LSB = 2;
    localparam int FLD_ECE_BIT = 4;
    localparam logic [4:0] RST_CTRL = 5'h00;
    localparam logic [1:0] EA_MCHECK = 2'h0;
    localparam logic [1:0] EA_CORRECT = 2'h1;
    localparam logic [1:0] TAG_PROTECTION_TYPE_EDC = 2'h1;
    localparam logic [1:0] KIND_LOAD = 2'h0;
    localparam logic [1:0] KIND_STORE = 2'h1;
    localparam logic [1:0] KIND_LR = 2'h2;
    localparam logic [1:0] KIND_SC = 2'h3;
    localparam logic [15:0] RST_MC_COUNT = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOOKUP,
        ST_CORRECT,
        ST_RELOOK,
        ST_REFILL,
        ST_PUSH,
        ST_RSV
    } l1cea_state_type;
endpackage
